// ---- mmfp_top.sv ----
// Operation
// - bottom 4KB of data space decodes as the I/O region.
// - first 64 I/O locations reachable directly and at data 0x00-0x3f.
// - extended I/O 0x0040-0x0fff reachable only as data-space addresses.
// - data 0x1000-0x1fff reserved for the mapped EEPROM view.
// - SRAM starts at data 0x2000; no instruction fetch from SRAM.
// - program and data addresses decode as two separate spaces.
// - application and boot sections each have write and read/write locks.
// - CPU flash writes take effect only when issued from the boot section.
// - application table subsection has its own write and read/write locks.
// - lock writes from CPU or programmer may only tighten protection.
// - only chip erase returns lock bits to unprotected.
// - chip erase clears lock bits after all flash pages are erased.
// - fuse and lock cells read one unprogrammed, zero programmed.
// - fuses written only by programmer, readable by software.
// - production signature row refuses writes and erases, readable by all.
// - calibration values copied from signature row automatically after reset.
// - signature row gives three device id bytes and unit serial number.
// - user signature row is one page, readable and writable by all.
// - chip erase spares user signature row; it has its own erase.
`timescale 1ns/10ps
`include "mmfp_consts.svh"

module mmfp_top #(
    parameter logic [7:0] DEV_ID0 = 8'ha5, // arbitrary value
    parameter logic [7:0] DEV_ID1 = 8'h5a, // arbitrary value
    parameter logic [7:0] DEV_ID2 = 8'h3c  // arbitrary value
) (
    // clock and reset
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_rst_b,
    // cpu data access decode
    input  wire logic                 i_cpu_dreq,
    input  wire logic                 i_cpu_io_direct,
    input  wire logic [15:0]          i_cpu_daddr,
    input  wire logic                 i_eep_map_en,
    output logic                      o_sel_io,
    output logic                      o_sel_eep,
    output logic                      o_sel_sram,
    output logic                      o_sel_none,
    output logic [15:0]               o_sel_addr,
    // nonvolatile access requests
    input  wire logic                 i_fl_req,
    input  wire logic                 i_fl_from_prog,
    input  mmfp_pkg::mmfp_op_e        i_fl_op,
    input  mmfp_pkg::mmfp_space_e     i_fl_space,
    input  wire logic [15:0]          i_fl_addr,
    input  wire logic [15:0]          i_fl_pc,
    input  wire logic [15:0]          i_fl_wdata,
    input  wire logic                 i_chip_erase,
    output logic                      o_fl_ack,
    output logic                      o_fl_denied,
    output logic [15:0]               o_fl_rdata,
    output logic                      o_busy,
    // nonvolatile array port
    input  wire logic                 i_nvm_busy,
    input  wire logic [15:0]          i_nvm_rdata,
    output logic                      o_nvm_rd,
    output logic                      o_nvm_wr,
    output logic                      o_nvm_er,
    output mmfp_pkg::mmfp_space_e     o_nvm_space,
    output logic [15:0]               o_nvm_addr,
    output logic [15:0]               o_nvm_wdata,
    // configuration outputs
    output logic [31:0]               o_fuse,
    output logic [7:0]                o_lock,
    output logic                      o_cal_we,
    output logic [3:0]                o_cal_idx,
    output logic [7:0]                o_cal_data,
    output logic                      o_load_done
);
    import mmfp_pkg::*;

    mmfp_state_e state_q;
    mmfp_state_e state_d;
    logic [3:0]  load_q;
    logic [8:0]  page_q;
    logic        denied_q;
    logic [1:0]  rsrc_q;
    logic [1:0]  lv;
    logic        is_wr;
    logic        allow;
    logic        take;
    logic [15:0] rd_val;

    // ****************************************
    // data space decode
    // ****************************************
    // program addresses never reach this decoder, so code fetch
    // cannot land in sram and equal numbers mean different storage
    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_sel_io   <= 1'b0;
            o_sel_eep  <= 1'b0;
            o_sel_sram <= 1'b0;
            o_sel_none <= 1'b0;
            o_sel_addr <= 16'h0000;
        end
        else if (!i_cpu_dreq)
        begin
            o_sel_io   <= 1'b0;
            o_sel_eep  <= 1'b0;
            o_sel_sram <= 1'b0;
            o_sel_none <= 1'b0;
        end
        else if (i_cpu_io_direct)
        begin
            // direct form only carries six bits: no extended i/o
            o_sel_io   <= 1'b1;
            o_sel_eep  <= 1'b0;
            o_sel_sram <= 1'b0;
            o_sel_none <= 1'b0;
            o_sel_addr <= {10'h000, i_cpu_daddr[5:0]};
        end
        else
        begin
            o_sel_io   <= i_cpu_daddr <= `MMFP_IO_LAST;
            o_sel_eep  <= i_eep_map_en && i_cpu_daddr >= `MMFP_EEP_BASE
                          && i_cpu_daddr <= `MMFP_EEP_LAST;
            o_sel_sram <= i_cpu_daddr >= `MMFP_SRAM_BASE
                          && i_cpu_daddr <= `MMFP_SRAM_LAST;
            o_sel_none <= (i_cpu_daddr > `MMFP_IO_LAST
                           && i_cpu_daddr < `MMFP_SRAM_BASE && !i_eep_map_en)
                          || i_cpu_daddr > `MMFP_SRAM_LAST;
            o_sel_addr <= i_cpu_daddr;
        end
    end

    // ****************************************
    // access check
    // ****************************************
    always_comb
    begin
        is_wr = i_fl_op != MMFP_OP_READ;
        if (i_fl_addr >= `MMFP_BOOT_BASE)
            lv = o_lock[`MMFP_LK_BOOT_LSB +: 2];
        else if (i_fl_addr >= `MMFP_TBL_BASE)
            lv = o_lock[`MMFP_LK_TBL_LSB +: 2];
        else
            lv = o_lock[`MMFP_LK_APP_LSB +: 2];
        unique case (i_fl_space)
            MMFP_SP_FLASH:
            begin
                // a programmed cell reads zero, so 11 is open
                allow = (lv == `MMFP_LK_OPEN)
                        || (lv == `MMFP_LK_WRBLK && !is_wr);
                if (is_wr && !i_fl_from_prog && i_fl_pc < `MMFP_BOOT_BASE)
                    allow = 1'b0;
            end
            MMFP_SP_USIG: allow = 1'b1;
            MMFP_SP_PSIG: allow = !is_wr;
            MMFP_SP_FUSE: allow = !is_wr || i_fl_from_prog;
            MMFP_SP_LOCK: allow = i_fl_op != MMFP_OP_ERASE;
            default:      allow = 1'b0;
        endcase
    end

    assign take = state_q == MMFP_ST_IDLE && i_fl_req && !i_nvm_busy;

    // ****************************************
    // sequencer
    // ****************************************
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            MMFP_ST_LOAD_RD:  state_d = MMFP_ST_LOAD_CAP;
            MMFP_ST_LOAD_CAP:
                state_d = load_q == `MMFP_LOAD_LAST ? MMFP_ST_IDLE
                                                    : MMFP_ST_LOAD_RD;
            MMFP_ST_IDLE:
                if (i_chip_erase)
                    state_d = MMFP_ST_CE_PAGE;
                else if (take)
                    state_d = MMFP_ST_ACC;
            MMFP_ST_ACC:      state_d = MMFP_ST_IDLE;
            MMFP_ST_CE_PAGE:
                if (!i_nvm_busy && !o_nvm_er && page_q == `MMFP_PAGE_COUNT)
                    state_d = MMFP_ST_CE_LOCK;
            MMFP_ST_CE_LOCK:  state_d = MMFP_ST_IDLE;
            default:          state_d = MMFP_ST_IDLE;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            state_q <= MMFP_ST_LOAD_RD;
        else
            state_q <= state_d;
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            load_q <= 4'h0;
            page_q <= 9'h000;
        end
        else
        begin
            if (state_q == MMFP_ST_LOAD_CAP)
                load_q <= load_q + 4'h1;
            if (state_q == MMFP_ST_IDLE)
                page_q <= 9'h000;
            else if (state_q == MMFP_ST_CE_PAGE && !i_nvm_busy && !o_nvm_er
                     && page_q != `MMFP_PAGE_COUNT)
                page_q <= page_q + 9'h001;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            o_busy <= 1'b1;
        else
            o_busy <= state_d != MMFP_ST_IDLE;
    end

    // ****************************************
    // nonvolatile array strobes
    // ****************************************
    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_nvm_rd    <= 1'b0;
            o_nvm_wr    <= 1'b0;
            o_nvm_er    <= 1'b0;
            o_nvm_space <= MMFP_SP_FLASH;
            o_nvm_addr  <= 16'h0000;
            o_nvm_wdata <= 16'h0000;
        end
        else
        begin
            o_nvm_rd <= 1'b0;
            o_nvm_wr <= 1'b0;
            o_nvm_er <= 1'b0;
            if (state_q == MMFP_ST_LOAD_RD)
            begin
                o_nvm_rd <= 1'b1;
                if (load_q < `MMFP_FUSE_BYTES)
                begin
                    o_nvm_space <= MMFP_SP_FUSE;
                    o_nvm_addr  <= {12'h000, load_q};
                end
                else if (load_q == `MMFP_LOCK_STEP)
                begin
                    o_nvm_space <= MMFP_SP_LOCK;
                    o_nvm_addr  <= 16'h0000;
                end
                else
                begin
                    o_nvm_space <= MMFP_SP_PSIG;
                    o_nvm_addr  <= `MMFP_CAL_SIG_BASE
                                   + {12'h000, load_q - `MMFP_CAL_FIRST};
                end
            end
            else if (state_q == MMFP_ST_CE_PAGE)
            begin
                // busy lags a strobe by a cycle; user sig row untouched
                if (!i_nvm_busy && !o_nvm_er && page_q != `MMFP_PAGE_COUNT)
                begin
                    o_nvm_er    <= 1'b1;
                    o_nvm_space <= MMFP_SP_FLASH;
                    o_nvm_addr  <= 16'(page_q) << `MMFP_PAGE_SHIFT;
                end
            end
            else if (state_q == MMFP_ST_CE_LOCK)
            begin
                o_nvm_wr    <= 1'b1;
                o_nvm_space <= MMFP_SP_LOCK;
                o_nvm_addr  <= 16'h0000;
                o_nvm_wdata <= {8'h00, `MMFP_LOCK_ERASED};
            end
            else if (take && !i_chip_erase)
            begin
                // blocked accesses never reach the array
                o_nvm_rd    <= allow && !is_wr;
                o_nvm_wr    <= allow && i_fl_op == MMFP_OP_WRITE;
                o_nvm_er    <= allow && i_fl_op == MMFP_OP_ERASE;
                o_nvm_space <= i_fl_space;
                o_nvm_addr  <= i_fl_addr;
                o_nvm_wdata <= i_fl_space == MMFP_SP_LOCK
                               ? {8'h00, o_lock & i_fl_wdata[7:0]}
                               : i_fl_wdata;
            end
        end
    end

    // ****************************************
    // lock and fuse shadows
    // ****************************************
    // locks start fully closed until the stored byte is loaded,
    // so nothing leaks in the cycles after reset
    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            o_lock <= `MMFP_LOCK_RST;
        else if (state_q == MMFP_ST_LOAD_CAP && load_q == `MMFP_LOCK_STEP)
            o_lock <= i_nvm_rdata[7:0];
        else if (state_q == MMFP_ST_CE_LOCK)
            o_lock <= `MMFP_LOCK_ERASED;
        else if (take && !i_chip_erase && allow && is_wr
                 && i_fl_space == MMFP_SP_LOCK)
            o_lock <= o_lock & i_fl_wdata[7:0];
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            o_fuse <= `MMFP_FUSE_RST;
        else if (state_q == MMFP_ST_LOAD_CAP && load_q < `MMFP_FUSE_BYTES)
            o_fuse[{load_q[1:0], 3'b000} +: 8] <= i_nvm_rdata[7:0];
        else if (take && !i_chip_erase && allow && is_wr
                 && i_fl_space == MMFP_SP_FUSE)
            o_fuse[{i_fl_addr[1:0], 3'b000} +: 8] <= i_fl_wdata[7:0];
    end

    // ****************************************
    // calibration copy after reset
    // ****************************************
    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_cal_we    <= 1'b0;
            o_cal_idx   <= 4'h0;
            o_cal_data  <= 8'h00;
            o_load_done <= 1'b0;
        end
        else
        begin
            o_cal_we <= state_q == MMFP_ST_LOAD_CAP
                        && load_q >= `MMFP_CAL_FIRST;
            o_cal_idx  <= load_q - `MMFP_CAL_FIRST;
            o_cal_data <= i_nvm_rdata[7:0];
            if (state_q == MMFP_ST_LOAD_CAP && load_q == `MMFP_LOAD_LAST)
                o_load_done <= 1'b1;
        end
    end

    // ****************************************
    // answer
    // ****************************************
    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            denied_q <= 1'b0;
            rsrc_q   <= 2'h0;
        end
        else if (take)
        begin
            denied_q <= !allow;
            if (i_fl_space == MMFP_SP_FUSE)
                rsrc_q <= 2'h1;
            else if (i_fl_space == MMFP_SP_LOCK)
                rsrc_q <= 2'h2;
            else if (i_fl_space == MMFP_SP_PSIG
                     && i_fl_addr <= `MMFP_ID_LAST)
                rsrc_q <= 2'h3;
            else
                rsrc_q <= 2'h0;
        end
    end

    always_comb
    begin
        unique case (rsrc_q)
            2'h1: rd_val = {8'h00, o_fuse[{o_nvm_addr[1:0], 3'b000} +: 8]};
            2'h2: rd_val = {8'h00, o_lock};
            2'h3: rd_val = o_nvm_addr[1:0] == 2'h0 ? {8'h00, DEV_ID0}
                         : o_nvm_addr[1:0] == 2'h1 ? {8'h00, DEV_ID1}
                         : {8'h00, DEV_ID2};
            default: rd_val = i_nvm_rdata;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_fl_ack    <= 1'b0;
            o_fl_denied <= 1'b0;
            o_fl_rdata  <= 16'h0000;
        end
        else
        begin
            o_fl_ack    <= state_q == MMFP_ST_ACC;
            o_fl_denied <= state_q == MMFP_ST_ACC && denied_q;
            if (state_q == MMFP_ST_ACC)
                o_fl_rdata <= denied_q ? 16'h0000 : rd_val;
        end
    end

endmodule

// ---- mmfp_consts.svh ----
`ifndef MMFP_CONSTS_SVH
`define MMFP_CONSTS_SVH

// ****************************************
// data space map
// ****************************************
`define MMFP_IO_DIRECT_LAST 16'h003f
`define MMFP_IO_LAST        16'h0fff
`define MMFP_EEP_BASE       16'h1000
`define MMFP_EEP_LAST       16'h1fff
`define MMFP_SRAM_BASE      16'h2000
`define MMFP_SRAM_LAST      16'h2fff

// ****************************************
// program space map, word addresses
// ****************************************
`define MMFP_TBL_BASE       16'h7000
`define MMFP_BOOT_BASE      16'h8000
`define MMFP_PAGE_SHIFT     7
`define MMFP_PAGE_COUNT     9'h110

// ****************************************
// lock byte fields and levels
// ****************************************
`define MMFP_LK_APP_LSB     0
`define MMFP_LK_TBL_LSB     2
`define MMFP_LK_BOOT_LSB    4
`define MMFP_LK_OPEN        2'h3
`define MMFP_LK_WRBLK       2'h2
`define MMFP_LOCK_RST       8'h00
`define MMFP_LOCK_ERASED    8'hff
`define MMFP_FUSE_RST       32'hffffffff

// ****************************************
// start-up load sequence
// ****************************************
`define MMFP_FUSE_BYTES     4'h4
`define MMFP_LOCK_STEP      4'h4
`define MMFP_CAL_FIRST      4'h5
`define MMFP_LOAD_LAST      4'h8
`define MMFP_CAL_SIG_BASE   16'h0010
`define MMFP_ID_LAST        16'h0002

`endif

// ---- mmfp_pkg.sv ----
package mmfp_pkg;

    typedef enum logic [2:0] {
        MMFP_ST_LOAD_RD = 3'b000,
        MMFP_ST_LOAD_CAP = 3'b001,
        MMFP_ST_IDLE = 3'b010,
        MMFP_ST_ACC = 3'b011,
        MMFP_ST_CE_PAGE = 3'b100,
        MMFP_ST_CE_LOCK = 3'b101
    } mmfp_state_e;

    typedef enum logic [2:0] {
        MMFP_SP_FLASH = 3'b000,
        MMFP_SP_USIG = 3'b001,
        MMFP_SP_PSIG = 3'b010,
        MMFP_SP_FUSE = 3'b011,
        MMFP_SP_LOCK = 3'b100
    } mmfp_space_e;

    typedef enum logic [1:0] {
        MMFP_OP_READ = 2'b00,
        MMFP_OP_WRITE = 2'b01,
        MMFP_OP_ERASE = 2'b10
    } mmfp_op_e;

endpackage

// ---- mmfp_top_chk.sv ----
`timescale 1ns/10ps
module mmfp_chk (
    // clock and reset
    input wire logic            i_sys_clk,
    input wire logic            i_rst_b,
    // watched inputs
    input wire logic            i_cpu_dreq,
    input wire logic            i_cpu_io_direct,
    input wire logic [15:0]     i_cpu_daddr,
    input wire logic            i_eep_map_en,
    input wire logic            i_fl_from_prog,
    input wire logic [15:0]     i_fl_pc,
    // watched outputs
    input wire logic            o_sel_io,
    input wire logic            o_sel_eep,
    input wire logic            o_sel_sram,
    input wire logic            o_sel_none,
    input wire logic [15:0]     o_sel_addr,
    input wire logic            o_fl_ack,
    input wire logic            o_fl_denied,
    input wire logic [15:0]     o_fl_rdata,
    input wire logic            o_nvm_rd,
    input wire logic            o_nvm_wr,
    input wire logic            o_nvm_er,
    input mmfp_pkg::mmfp_space_e o_nvm_space,
    input wire logic [7:0]      o_lock,
    input wire logic            o_load_done
);
    import mmfp_pkg::*;
    logic dacc;
    assign dacc = i_cpu_dreq && !i_cpu_io_direct;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);

    AST_IO: assert property (dacc && i_cpu_daddr <= 16'h0fff |=> o_sel_io
        && o_sel_addr == $past(i_cpu_daddr)) else $error("io decode wrong");
    AST_DIRECT: assert property (i_cpu_dreq && i_cpu_io_direct |=> o_sel_io
        && o_sel_addr == {10'h000, $past(i_cpu_daddr[5:0])}) else $error("direct io wrong");
    AST_EEP: assert property (dacc && i_cpu_daddr[15:12] == 4'h1
        |=> o_sel_eep == $past(i_eep_map_en) && o_sel_none != $past(i_eep_map_en))
        else $error("eeprom window wrong");
    AST_SRAM: assert property (dacc && i_cpu_daddr[15:12] >= 4'h2
        |=> o_sel_sram == ($past(i_cpu_daddr[15:12]) == 4'h2)) else $error("sram decode wrong");
    AST_DENY: assert property (o_fl_denied |-> o_fl_ack && o_fl_rdata == 16'h0000)
        else $error("denied access leaked data");
    AST_NOSTROBE: assert property (o_fl_ack && o_fl_denied |-> !$past(o_nvm_rd)
        && !$past(o_nvm_wr) && !$past(o_nvm_er)) else $error("denied access hit array");
    AST_LOOSEN: assert property ($past(o_load_done) && (o_lock & ~$past(o_lock)) != 8'h00
        |-> o_nvm_wr && o_nvm_space == MMFP_SP_LOCK && o_lock == 8'hff)
        else $error("lock loosened outside erase");
    AST_CE_HOLD: assert property (o_nvm_er && o_nvm_space == MMFP_SP_FLASH |-> $stable(o_lock))
        else $error("lock changed during erase");
    AST_FUSE: assert property (o_nvm_wr && o_nvm_space == MMFP_SP_FUSE |-> $past(i_fl_from_prog))
        else $error("cpu wrote fuse");
    AST_PSIG: assert property ((o_nvm_wr || o_nvm_er) |-> o_nvm_space != MMFP_SP_PSIG)
        else $error("signature row altered");
    AST_BOOT: assert property (o_nvm_wr && o_nvm_space == MMFP_SP_FLASH && !$past(i_fl_from_prog)
        |-> $past(i_fl_pc) >= 16'h8000) else $error("cpu flash write outside boot");

    CV_DENY: cover property (o_fl_ack && o_fl_denied);
    CV_ERASE: cover property (o_nvm_er && o_nvm_space == MMFP_SP_FLASH);
    CV_EEP: cover property (o_sel_eep);
endmodule

bind mmfp_top mmfp_chk u_chk (.i_sys_clk, .i_rst_b, .i_cpu_dreq, .i_cpu_io_direct, .i_cpu_daddr,
    .i_eep_map_en, .i_fl_from_prog, .i_fl_pc, .o_sel_io, .o_sel_eep, .o_sel_sram, .o_sel_none,
    .o_sel_addr, .o_fl_ack, .o_fl_denied, .o_fl_rdata, .o_nvm_rd, .o_nvm_wr, .o_nvm_er,
    .o_nvm_space, .o_lock, .o_load_done);

// ---- mmfp_nvm_model.sv ----
`timescale 1ns/10ps
module mmfp_nvm_model #(
    parameter int BUSY_CYC = 3
) (
    // clock and reset
    input wire logic            i_sys_clk,
    input wire logic            i_rst_b,
    // array port
    input wire logic            i_rd,
    input wire logic            i_wr,
    input wire logic            i_er,
    input mmfp_pkg::mmfp_space_e i_space,
    input wire logic [15:0]     i_addr,
    input wire logic [15:0]     i_wdata,
    output logic                o_busy,
    output logic [15:0]         o_rdata
);
    import mmfp_pkg::*;
    logic [15:0] mem [0:2047];
    logic [15:0] last_q = 16'h0000;
    int          cnt_q;
    logic [10:0] idx;
    assign idx = {i_space, i_addr[7:0]};
    // idle data lines show the inverted last word read so a stale word is never mistaken for a read
    assign o_rdata = i_rd ? mem[idx] : ~last_q;
    assign o_busy = cnt_q != 0;
    initial
    begin
        for (int k = 0; k < 2048; k++)
            mem[k] = 16'(k) ^ 16'h5a5a;
        mem[11'h400] = 16'h00ff;
    end
    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            cnt_q <= 0;
        else if (i_wr || i_er)
            cnt_q <= BUSY_CYC;
        else if (cnt_q != 0)
            cnt_q <= cnt_q - 1;
    end
    always @(posedge i_sys_clk)
    begin
        if (i_rd)
            last_q <= mem[idx];
        if (i_wr)
            mem[idx] <= i_wdata;
        if (i_er)
            for (int k = 0; k < 128; k++)
                mem[{idx[10:7], 7'(k)}] <= 16'hffff;
    end
endmodule

// ---- test_memory_map_and_flash_protection.sv ----
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin mismatches++; \
    $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module test_memory_map_and_flash_protection;
    import mmfp_pkg::*;
    logic        i_sys_clk = 0, i_rst_b = 0, i_cpu_dreq = 0, i_cpu_io_direct = 0;
    logic        i_eep_map_en = 0, i_fl_req = 0, i_fl_from_prog = 0, i_chip_erase = 0;
    logic [15:0] i_cpu_daddr = 0, i_fl_addr = 0, i_fl_pc = 0, i_fl_wdata = 0;
    mmfp_op_e    i_fl_op = MMFP_OP_READ;
    mmfp_space_e i_fl_space = MMFP_SP_FLASH, o_nvm_space;
    logic        o_sel_io, o_sel_eep, o_sel_sram, o_sel_none, o_fl_ack, o_fl_denied, o_busy;
    logic        i_nvm_busy, o_nvm_rd, o_nvm_wr, o_nvm_er, o_cal_we, o_load_done;
    logic [15:0] o_sel_addr, o_fl_rdata, i_nvm_rdata, o_nvm_addr, o_nvm_wdata;
    logic [31:0] o_fuse;
    logic [7:0]  o_lock, o_cal_data;
    logic [3:0]  o_cal_idx;
    logic [7:0]  cal [0:3];
    int          mismatches = 0, num_checks = 0;
    localparam mmfp_op_e    RD = MMFP_OP_READ, WR = MMFP_OP_WRITE, ER = MMFP_OP_ERASE;
    localparam mmfp_space_e FL = MMFP_SP_FLASH, US = MMFP_SP_USIG, PS = MMFP_SP_PSIG;
    localparam mmfp_space_e FU = MMFP_SP_FUSE, LK = MMFP_SP_LOCK;

    always #2 i_sys_clk = ~i_sys_clk;

    mmfp_top uut (.i_sys_clk, .i_rst_b, .i_cpu_dreq, .i_cpu_io_direct, .i_cpu_daddr,
        .i_eep_map_en, .o_sel_io, .o_sel_eep, .o_sel_sram, .o_sel_none, .o_sel_addr,
        .i_fl_req, .i_fl_from_prog, .i_fl_op, .i_fl_space, .i_fl_addr, .i_fl_pc, .i_fl_wdata,
        .i_chip_erase, .o_fl_ack, .o_fl_denied, .o_fl_rdata, .o_busy, .i_nvm_busy,
        .i_nvm_rdata, .o_nvm_rd, .o_nvm_wr, .o_nvm_er, .o_nvm_space, .o_nvm_addr, .o_nvm_wdata,
        .o_fuse, .o_lock, .o_cal_we, .o_cal_idx, .o_cal_data, .o_load_done);
    mmfp_nvm_model #(.BUSY_CYC(3)) u_nvm (.i_sys_clk, .i_rst_b, .i_rd(o_nvm_rd),
        .i_wr(o_nvm_wr), .i_er(o_nvm_er), .i_space(o_nvm_space), .i_addr(o_nvm_addr),
        .i_wdata(o_nvm_wdata), .o_busy(i_nvm_busy), .o_rdata(i_nvm_rdata));

    always @(posedge i_sys_clk)
        if (o_cal_we === 1'b1)
            cal[o_cal_idx[1:0]] <= o_cal_data;

    task automatic end_sim();
        if (mismatches == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic nv(input logic pr, input mmfp_op_e op, input mmfp_space_e sp,
        input logic [15:0] a, wd, pc,
        input logic den, input logic [15:0] rd);
        @(posedge i_sys_clk);
        i_fl_req <= 1'b1;
        i_fl_from_prog <= pr;
        i_fl_op <= op;
        i_fl_space <= sp;
        i_fl_addr <= a;
        i_fl_wdata <= wd;
        i_fl_pc <= pc;
        do
            @(negedge i_sys_clk);
        while (o_busy !== 1'b0 || i_nvm_busy !== 1'b0);
        @(posedge i_sys_clk);
        i_fl_req <= 1'b0;
        @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        `CHK("ack", 1'b1, o_fl_ack)
        `CHK("denied", den, o_fl_denied)
        if (op == RD || den)
            `CHK("rdata", rd, o_fl_rdata)
    endtask

    task automatic t_reset(input logic [7:0] lk, input logic [31:0] fu);
        @(posedge i_sys_clk);
        i_rst_b <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        `CHK("rst busy", 1'b1, o_busy)
        `CHK("rst lock", 8'h00, o_lock)
        `CHK("rst fuse", 32'hffffffff, o_fuse)
        i_rst_b <= 1'b1;
        while (o_load_done !== 1'b1)
            @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        `CHK("fuse", fu, o_fuse)
        `CHK("lock", lk, o_lock)
        for (int k = 0; k < 4; k++)
            `CHK("cal", 8'h4a ^ 8'(k), cal[k])
    endtask

    task automatic t_decode();
        logic [15:0] a [10] = '{16'h123f, 16'h003f, 16'h0040, 16'h0fff, 16'h1000,
            16'h1fff, 16'h2000, 16'h2fff, 16'h3000, 16'h2000};
        logic [3:0]  e [10] = '{4'h8, 4'h8, 4'h8, 4'h8, 4'h4, 4'h1, 4'h2, 4'h2, 4'h1, 4'h0};
        for (int k = 0; k < 11; k++)
        begin
            @(posedge i_sys_clk);
            i_cpu_dreq <= (k < 9);
            i_cpu_io_direct <= (k == 0);
            i_eep_map_en <= (k == 4);
            i_cpu_daddr <= a[k % 10];
            if (k > 0)
            begin
                @(negedge i_sys_clk);
                `CHK("sel", e[k-1], {o_sel_io, o_sel_eep, o_sel_sram, o_sel_none})
                if (k < 10)
                    `CHK("sel addr", (k == 1) ? 16'h003f : a[k-1], o_sel_addr)
            end
        end
    endtask

    task automatic t_access();
        nv(0, RD, FL, 16'h0100, 0, 0, 0, 16'h5a5a);
        nv(0, WR, FL, 16'h0100, 16'h1234, 16'h1000, 1, 0);
        nv(0, WR, FL, 16'h0100, 16'h1234, 16'h8000, 0, 0);
        nv(0, RD, FL, 16'h0100, 0, 0, 0, 16'h1234);
        nv(0, RD, FU, 16'h0002, 0, 0, 0, 16'h0058);
        nv(0, WR, FU, 16'h0002, 16'h0012, 16'h8000, 1, 0);
        nv(1, WR, FU, 16'h0002, 16'h0012, 0, 0, 0);
        nv(0, RD, FU, 16'h0002, 0, 0, 0, 16'h0012);
        nv(1, RD, PS, 16'h0000, 0, 0, 0, 16'h00a5);
        nv(0, RD, PS, 16'h0001, 0, 0, 0, 16'h005a);
        nv(1, RD, PS, 16'h0002, 0, 0, 0, 16'h003c);
        nv(1, WR, PS, 16'h0000, 16'h0000, 0, 1, 0);
        nv(1, ER, PS, 16'h0010, 0, 0, 1, 0);
        nv(0, WR, US, 16'h0005, 16'hbeef, 16'h8000, 0, 0);
        nv(1, RD, US, 16'h0005, 0, 0, 0, 16'hbeef);
        nv(0, WR, LK, 0, 16'h00fe, 16'h8000, 0, 0);
        `CHK("lock app", 8'hfe, o_lock)
        nv(1, WR, FL, 16'h0100, 16'h0000, 0, 1, 0);
        nv(1, RD, FL, 16'h0100, 0, 0, 0, 16'h1234);
        nv(1, WR, LK, 0, 16'h00ff, 0, 0, 0);
        `CHK("lock loosen", 8'hfe, o_lock)
        nv(1, ER, LK, 0, 0, 0, 1, 0);
        nv(1, WR, LK, 0, 16'h00f3, 0, 0, 0);
        nv(1, RD, FL, 16'h7000, 0, 0, 1, 0);
        nv(1, RD, FL, 16'h6fff, 0, 0, 0, 16'h5aa5);
        nv(1, WR, LK, 0, 16'h00cf, 0, 0, 0);
        nv(1, RD, FL, 16'h8000, 0, 0, 1, 0);
        `CHK("lock boot", 8'hc2, o_lock)
    endtask

    task automatic t_erase();
        @(posedge i_sys_clk);
        i_chip_erase <= 1'b1;
        @(posedge i_sys_clk);
        i_chip_erase <= 1'b0;
        @(negedge i_sys_clk);
        while (o_busy !== 1'b0)
            @(negedge i_sys_clk);
        `CHK("erase lock", 8'hff, o_lock)
        `CHK("erase fuse", 32'h59125b5a, o_fuse)
        nv(1, RD, FL, 16'h0100, 0, 0, 0, 16'hffff);
        nv(1, RD, US, 16'h0005, 0, 0, 0, 16'hbeef);
        nv(1, ER, US, 16'h0000, 0, 0, 0, 0);
        nv(0, RD, US, 16'h0005, 0, 0, 0, 16'hffff);
    endtask

    initial
    begin
        #40000;
        mismatches++;
        end_sim();
    end

    initial
    begin
        t_reset(8'hff, 32'h59585b5a);
        t_decode();
        t_access();
        t_reset(8'hc2, 32'h59125b5a);
        t_erase();
        end_sim();
    end
endmodule
